// ==== design/vector_map_pkg.sv ====
// Constants, field layouts and carrier types for the vector map block
package vector_map_pkg;

  // Program address width in words
  localparam int ADDR_W = 16;
  // Number of interrupt sources behind the reset slot
  localparam int IRQ_COUNT = 20;
  // Vector number of the reset slot
  localparam logic [4:0] RESET_SLOT = 5'h01;
  // Program words occupied by one vector slot
  localparam logic [ADDR_W-1:0] SLOT_WORDS = 16'h0002;
  // Reset address with the fuse unprogrammed
  localparam logic [ADDR_W-1:0] APP_RESET_ADDR = 16'h0000;
  // Table base with the select bit clear
  localparam logic [ADDR_W-1:0] APP_TABLE_BASE = 16'h0000;
  // Last printed slot address in the table
  localparam logic [ADDR_W-1:0] LAST_SLOT_ADDR = 16'h0028;
  // Fuse level that means unprogrammed
  localparam logic FUSE_UNPROGRAMMED = 1'b1;

  // Cycles the change-enable bit stays open
  localparam logic [2:0] CHANGE_WINDOW_CYCLES = 3'h4;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] PENDING_OFFSET = 8'h08;
  localparam logic [7:0] TAKEN_OFFSET = 8'h0c;

  // Control register fields
  localparam int CTRL_CHANGE_BIT = 0;
  localparam int CTRL_SELECT_BIT = 1;
  // Status register fields
  localparam int STATUS_FUSE_BIT = 0;
  localparam int STATUS_BLOCKED_BIT = 1;
  localparam int STATUS_HOLD_BIT = 2;
  localparam int STATUS_VALID_BIT = 3;
  // Taken register fields
  localparam int TAKEN_NUM_LSB = 16;
  // Reset values
  localparam logic CTRL_SELECT_RESET = 1'b0;
  localparam logic [ADDR_W-1:0] TAKEN_ADDR_RESET = 16'h0000;

  // Request lines, bit 0 is the lowest vector number (slot 2)
  typedef struct packed {
    logic self_program_ready_irq;
    logic timer_zero_compare_irq;
    logic ext_request_two;
    logic two_wire_irq;
    logic comparator_irq;
    logic eeprom_ready_irq;
    logic converter_done_irq;
    logic uart_transmit_done_irq;
    logic uart_tx_buffer_empty_irq;
    logic uart_receive_done_irq;
    logic serial_transfer_done_irq;
    logic timer_zero_overflow_irq;
    logic wide_timer_overflow_irq;
    logic wide_timer_compare_b_irq;
    logic wide_timer_compare_a_irq;
    logic wide_timer_capture_irq;
    logic timer_two_overflow_irq;
    logic timer_two_compare_irq;
    logic ext_request_one;
    logic ext_request_zero;
  } irq_lines_type;

  // Vector handed to the core
  typedef struct packed {
    logic [4:0] num;
    logic [ADDR_W-1:0] addr;
  } vector_type;

  // Vector-select change sequence
  typedef enum logic [1:0] {
    CHG_IDLE = 2'b00,
    CHG_OPEN = 2'b01,
    CHG_HOLD = 2'b11
  } change_state_type;

  // Slot address: table base plus two words per slot after the first
  function automatic logic [ADDR_W-1:0] slot_addr(
    input logic [ADDR_W-1:0] base,
    input logic [4:0] num
  );
    logic [ADDR_W-1:0] ofs;
    ofs = SLOT_WORDS * ADDR_W'(num - RESET_SLOT);
    return base + ofs;
  endfunction

endpackage

// ==== design/irq_priority_pick.sv ====
// Lowest-index-first picker over the pending request lines
`timescale 1ns/1ns
module irq_priority_pick #(
  parameter int N = 20
) (
  input wire logic [N-1:0] req,
  output logic any,
  output logic [4:0] idx
);

  // Vector number is index plus two and must still fit in five bits
  if (N < 1 || N > 30) begin : g_bad_n
    $error("irq_priority_pick: N out of range");
  end

  // Walk from the top down so the lowest set line is left last
  always_comb begin
    any = 1'b0;
    idx = 5'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = 5'(i);
      end
    end
  end

endmodule

// ==== design/reset_interrupt_vector_map.sv ====
// Reset and interrupt vector address generator with APB control
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
// Register map (byte offsets, one 32-bit word each)
//   0x00 control: bit0 change-enable, bit1 vector-select
//   0x04 status: bit0 fuse, bit1 blocked, bit2 hold, bit3 offer valid
//   0x08 pending: request lines 19:0, bit0 is vector two
//   0x0c taken: bits 20:16 vector number, bits 15:0 address
//
// Limitations: the fuse is caught once per reset; a select write
// with no open window is dropped silently; an enable write during
// the hold state is ignored, so the hold ends on its own retire.
// The offer waits one idle cycle after each acknowledge so that the
// source has time to drop its request.
module reset_interrupt_vector_map
  import vector_map_pkg::*;
#(
  parameter logic [ADDR_W-1:0] BOOT_RESET_ADDR = 16'h1c00
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic boot_reset_fuse,
  input wire irq_lines_type irq_lines,
  input wire logic global_irq_enable,
  input wire logic instr_done,
  input wire logic irq_ack,
  output logic irq_valid,
  output vector_type irq_vector,
  output logic reset_fetch,
  output logic [ADDR_W-1:0] reset_vector_addr,
  output logic irq_blocked
);

  // Boot address must be word-pair aligned and leave room for the table
  if (BOOT_RESET_ADDR[0] != 1'b0 ||
      BOOT_RESET_ADDR > ~LAST_SLOT_ADDR) begin : g_bad_boot
    $error("reset_interrupt_vector_map: bad BOOT_RESET_ADDR");
  end

  // Bus decode
  logic wr_access; // Write taking effect this edge
  logic ctrl_hit; // Access to the control register
  logic mapped; // Address decodes to a register
  logic wr_change; // Change-enable written to one
  logic wr_select; // Write with change-enable zero

  // Change sequence state
  change_state_type chg_state_reg, chg_state_next;
  logic [2:0] chg_count_reg, chg_count_next; // Cycles left in window
  logic select_reg, select_next; // Vector-select bit

  // Reset-time capture
  logic started_reg, started_next; // First edge after release seen
  logic fuse_reg, fuse_next; // Fuse level caught at release
  logic reset_fetch_reg, reset_fetch_next;
  logic [ADDR_W-1:0] reset_addr_reg, reset_addr_next;

  // Offered vector
  logic valid_reg, valid_next;
  vector_type vector_reg, vector_next;
  vector_type taken_reg, taken_next; // Last vector the core took
  logic blocked; // Interrupt entry suppressed
  logic pick_any; // Some request pending
  logic [4:0] pick_idx; // Lowest pending line
  logic [ADDR_W-1:0] table_base; // Current table base

  // Read data
  logic [31:0] rdata;
  logic [31:0] prdata_reg, prdata_next; // Read data register

  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_access = psel & penable & pwrite;
  assign ctrl_hit = (paddr == CTRL_OFFSET);
  assign mapped = ctrl_hit || (paddr == STATUS_OFFSET) ||
                  (paddr == PENDING_OFFSET) || (paddr == TAKEN_OFFSET);
  // Error only in the access phase of an unmapped address
  assign pslverr = psel & penable & ~mapped;
  // Change-enable set opens the window; clear carries the select value
  assign wr_change = wr_access & ctrl_hit & pwdata[CTRL_CHANGE_BIT];
  assign wr_select = wr_access & ctrl_hit & ~pwdata[CTRL_CHANGE_BIT];

  // Change sequence next state
  always_comb begin
    chg_state_next = chg_state_reg;
    chg_count_next = chg_count_reg;
    select_next = select_reg;
    case (chg_state_reg)
      CHG_IDLE: begin
        // A select write without an open window is ignored
        if (wr_change) begin
          chg_state_next = CHG_OPEN;
          chg_count_next = CHANGE_WINDOW_CYCLES;
        end
      end
      CHG_OPEN: begin
        if (wr_select) begin
          // Select lands and change-enable drops at once
          select_next = pwdata[CTRL_SELECT_BIT];
          chg_count_next = 3'h0;
          chg_state_next = CHG_HOLD;
        end else if (wr_change) begin
          // Rewriting the enable restarts the window
          chg_count_next = CHANGE_WINDOW_CYCLES;
        end else if (chg_count_reg == 3'h1) begin
          chg_count_next = 3'h0;
          chg_state_next = CHG_IDLE;
        end else begin
          chg_count_next = chg_count_reg - 3'h1;
        end
      end
      CHG_HOLD: begin
        // Stay blocked until the instruction after the write retires
        if (instr_done) begin
          chg_state_next = CHG_IDLE;
        end
      end
      default: begin
        chg_state_next = CHG_IDLE;
        chg_count_next = 3'h0;
      end
    endcase
  end

  // Change sequence registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_state_reg <= CHG_IDLE;
      chg_count_reg <= 3'h0;
      select_reg <= CTRL_SELECT_RESET;
    end else begin
      chg_state_reg <= chg_state_next;
      chg_count_reg <= chg_count_next;
      select_reg <= select_next;
    end
  end

  // Global enable flag is left alone; only entry is gated here
  assign blocked = (chg_state_reg != CHG_IDLE);
  assign irq_blocked = blocked;

  // Reset capture: fuse is a strap, caught on the first clocked edge
  always_comb begin
    started_next = 1'b1;
    fuse_next = fuse_reg;
    reset_fetch_next = 1'b0;
    reset_addr_next = reset_addr_reg;
    // Only the first edge after release loads the capture
    if (!started_reg) begin
      fuse_next = boot_reset_fuse;
      reset_fetch_next = 1'b1;
      if (boot_reset_fuse == FUSE_UNPROGRAMMED) begin
        reset_addr_next = APP_RESET_ADDR;
      end else begin
        reset_addr_next = BOOT_RESET_ADDR;
      end
    end
  end

  // Reset capture registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      started_reg <= 1'b0;
      fuse_reg <= FUSE_UNPROGRAMMED;
      reset_fetch_reg <= 1'b0;
      reset_addr_reg <= APP_RESET_ADDR;
    end else begin
      started_reg <= started_next;
      fuse_reg <= fuse_next;
      reset_fetch_reg <= reset_fetch_next;
      reset_addr_reg <= reset_addr_next;
    end
  end

  // Reset outputs come straight from their flip-flops
  assign reset_fetch = reset_fetch_reg;
  assign reset_vector_addr = reset_addr_reg;

  // Pick the lowest pending line
  irq_priority_pick #(
    .N(IRQ_COUNT)
  ) u_pick (
    .req(irq_lines),
    .any(pick_any),
    .idx(pick_idx)
  );

  // Table base moves into the boot section with the select bit
  assign table_base = select_reg ? BOOT_RESET_ADDR : APP_TABLE_BASE;

  // Offered vector next values
  always_comb begin
    valid_next = valid_reg;
    vector_next = vector_reg;
    taken_next = taken_reg;
    if (valid_reg && irq_ack) begin
      // Core took it; one idle cycle lets the source flag clear
      taken_next = vector_reg;
      valid_next = 1'b0;
    end else if (blocked || !global_irq_enable) begin
      // Blocking or a cleared I flag withdraws a standing offer
      valid_next = 1'b0;
    end else if (!valid_reg && pick_any) begin
      // Held stable while offered so the core sees one address
      valid_next = 1'b1;
      vector_next.num = pick_idx + 5'h02;
      // Slots 2..21 give 0x002..0x028 from the base
      vector_next.addr = slot_addr(table_base,
                         vector_next.num);
    end
  end

  // Offered vector registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_reg <= 1'b0;
      vector_reg <= '0;
      taken_reg <= '0;
    end else begin
      valid_reg <= valid_next;
      vector_reg <= vector_next;
      taken_reg <= taken_next;
    end
  end

  // Offer outputs come straight from their flip-flops
  assign irq_valid = valid_reg;
  assign irq_vector = vector_reg;

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata = 32'h0000_0000;
    case (paddr)
      CTRL_OFFSET: begin
        rdata[CTRL_SELECT_BIT] = select_reg;
        rdata[CTRL_CHANGE_BIT] = (chg_state_reg == CHG_OPEN);
      end
      STATUS_OFFSET: begin
        rdata[STATUS_FUSE_BIT] = fuse_reg;
        rdata[STATUS_BLOCKED_BIT] = blocked;
        rdata[STATUS_HOLD_BIT] = (chg_state_reg == CHG_HOLD);
        rdata[STATUS_VALID_BIT] = valid_reg;
      end
      PENDING_OFFSET: begin
        rdata[IRQ_COUNT-1:0] = irq_lines;
      end
      TAKEN_OFFSET: begin
        rdata[ADDR_W-1:0] = taken_reg.addr;
        rdata[TAKEN_NUM_LSB +: 5] = taken_reg.num;
      end
      default: begin
        rdata = 32'h0000_0000;
      end
    endcase
  end

  // Read data loaded in the setup cycle, shown in the access cycle and
  // cleared after it, so the bus sees a flip-flop with no wait state.
  // Trade-off: a read reports state one cycle before the access edge.
  always_comb begin
    prdata_next = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      prdata_next = rdata; // Setup cycle of a read
    end
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;

endmodule

// ==== bench/vector_map_monitor.sv ====
// Port checks for the vector map block
`timescale 1ns/1ns
module vector_map_monitor
  import vector_map_pkg::*;
#(
  parameter logic [ADDR_W-1:0] BOOT_RESET_ADDR = 16'h1c00
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic boot_reset_fuse,
  input wire irq_lines_type irq_lines,
  input wire logic global_irq_enable,
  input wire logic irq_ack,
  input wire logic irq_valid,
  input wire vector_type irq_vector,
  input wire logic reset_fetch,
  input wire logic [ADDR_W-1:0] reset_vector_addr,
  input wire logic irq_blocked
);
  logic ctrl_wr; // Control write accepted
  logic en_wr; // Change-enable write accepted
  logic [4:0] low_num; // Lowest pending vector number
  logic [ADDR_W-1:0] ofs; // Slot offset of the offer
  // Decode writes and the expected winner
  always_comb begin
    ctrl_wr = psel && penable && pwrite && paddr == CTRL_OFFSET;
    en_wr = ctrl_wr && pwdata[CTRL_CHANGE_BIT];
    ofs = ADDR_W'(irq_vector.num - RESET_SLOT) << 1;
    low_num = 5'h00;
    for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
      if (irq_lines[i]) begin
        low_num = 5'(i + 2);
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RST_ADDR: assert property (reset_fetch |->
    reset_vector_addr == ($past(boot_reset_fuse) == FUSE_UNPROGRAMMED ?
    APP_RESET_ADDR : BOOT_RESET_ADDR)) else $error("reset address wrong");
  AST_FETCH_ONCE: assert property (reset_fetch |=> !reset_fetch)
    else $error("reset fetch not one cycle");
  AST_VEC_ADDR: assert property (irq_valid |-> irq_vector.addr == ofs ||
    irq_vector.addr == BOOT_RESET_ADDR + ofs) else $error("bad vector");
  AST_VEC_RANGE: assert property (irq_valid |->
    irq_vector.num inside {[5'h02:5'h15]}) else $error("bad number");
  AST_PRIO: assert property ($rose(irq_valid) |->
    irq_vector.num == $past(low_num)) else $error("wrong winner");
  AST_NO_OFFER: assert property ($rose(irq_valid) |->
    $past(!irq_blocked && global_irq_enable)) else $error("offer blocked");
  AST_BLOCK_LEN: assert property (en_wr |=> irq_blocked[*3])
    else $error("block too short");
  AST_WIN_CLOSE: assert property (en_wr ##1 !ctrl_wr[*4]
    |=> !irq_blocked) else $error("window not closed");
  cover property (reset_fetch && !boot_reset_fuse);
  cover property (irq_valid && irq_ack && irq_vector.num == 5'h15);
  cover property (en_wr ##2 ctrl_wr);
endmodule
bind reset_interrupt_vector_map vector_map_monitor #(
  .BOOT_RESET_ADDR(BOOT_RESET_ADDR)) mon (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .boot_reset_fuse(boot_reset_fuse),
  .irq_lines(irq_lines), .global_irq_enable(global_irq_enable),
  .irq_ack(irq_ack), .irq_valid(irq_valid), .irq_vector(irq_vector),
  .reset_fetch(reset_fetch), .reset_vector_addr(reset_vector_addr),
  .irq_blocked(irq_blocked));

// ==== bench/core_model.sv ====
// Core-side model: retires instructions and accepts offers
`timescale 1ns/1ns
module core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_valid,
  output logic irq_ack,
  output logic instr_done
);
  logic [1:0] cnt_reg; // Instruction pacing
  logic [1:0] cnt_next;
  // Next pacing count
  always_comb begin
    cnt_next = cnt_reg + 2'h1;
  end
  // Ack only on odd counts, so some offers must stand a while
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 2'h0;
      irq_ack <= 1'b0;
      instr_done <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      instr_done <= cnt_reg == 2'h3;
      irq_ack <= irq_valid && !irq_ack && cnt_reg[0];
    end
  end
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the vector map block
`timescale 1ns/1ns
module tb;
  import vector_map_pkg::*;
  localparam logic [ADDR_W-1:0] BOOT = 16'h1c00;
  logic pclk, presetn, psel, penable, pwrite, fuse, gie, pready, pslverr;
  logic irq_valid, irq_ack, instr_done, reset_fetch, irq_blocked, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [ADDR_W-1:0] rst_addr;
  irq_lines_type lines;
  vector_type vec;
  int errors = 0;
  int num_checks = 0;
  reset_interrupt_vector_map #(.BOOT_RESET_ADDR(BOOT)) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .boot_reset_fuse(fuse), .irq_lines(lines), .global_irq_enable(gie),
    .instr_done(instr_done), .irq_ack(irq_ack), .irq_valid(irq_valid),
    .irq_vector(vec), .reset_fetch(reset_fetch),
    .reset_vector_addr(rst_addr), .irq_blocked(irq_blocked));
  core_model core (.pclk(pclk), .presetn(presetn), .irq_valid(irq_valid),
    .irq_ack(irq_ack), .instr_done(instr_done));
  // Free-running clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task close_out();
    if (errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // A used-up wait is a mismatch and ends the run
  task bound(input int n);
    if (n >= 50) begin
      errors++;
      close_out();
    end
  endtask
  // Reset, then look at the fetch pulse in the cycle it stands
  task rst(input logic f, input logic [ADDR_W-1:0] a);
    presetn <= 1'b0;
    fuse <= f;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    chk(reset_fetch, 1'b1);
    chk(rst_addr, a);
    @(posedge pclk);
  endtask
  // Setup then access; the request stays up until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (n = 0; n < 50 && pready !== 1'b1; n++) begin
      @(posedge pclk);
    end
    bound(n);
    rd = prdata;
    er = pslverr;
  endtask
  task idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wait_valid(input logic v);
    int n;
    for (n = 0; n < 50 && irq_valid !== v; n++) begin
      @(posedge pclk);
    end
    bound(n);
  endtask
  task wait_free();
    int n;
    for (n = 0; n < 50 && irq_blocked !== 1'b0; n++) begin
      @(posedge pclk);
    end
    bound(n);
  endtask
  // Wait for the offer, check it, drop the request, let the core take it
  task offer(input logic [4:0] num, input logic [31:0] addr);
    wait_valid(1'b1);
    chk(vec.num, num);
    chk(vec.addr, addr);
    lines <= '0;
    wait_valid(1'b0);
  endtask
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    gie = 1'b0;
    lines = '0;
    rst(1'b0, BOOT);
    rst(1'b1, 16'h0000);
    @(posedge pclk);
    lines <= 20'h80001;
    repeat (3) @(posedge pclk);
    apb(0, PENDING_OFFSET, 0);
    chk(rd, 32'h80001);
    chk(irq_valid, 0);
    idle();
    gie <= 1'b1;
    for (int i = 0; i < IRQ_COUNT; i++) begin
      lines <= 20'h80000 | (20'h1 << i);
      offer(5'(i + 2), 2 * i + 2);
    end
    apb(0, TAKEN_OFFSET, 0);
    chk(rd, 32'h00150028);
    idle();
    lines.ext_request_two <= 1'b1;
    offer(5'h13, 32'h024);
    lines.wide_timer_capture_irq <= 1'b1;
    offer(5'h06, 32'h00a);
    lines.uart_receive_done_irq <= 1'b1;
    offer(5'h0c, 32'h016);
    lines.converter_done_irq <= 1'b1;
    offer(5'h0f, 32'h01c);
    lines.two_wire_irq <= 1'b1;
    offer(5'h12, 32'h022);
    apb(1, CTRL_OFFSET, 32'h2);
    apb(1, CTRL_OFFSET, 32'h1);
    lines <= 20'h1;
    apb(0, STATUS_OFFSET, 0);
    chk(rd, 32'h3);
    chk(irq_blocked, 1);
    idle();
    @(posedge pclk);
    chk(irq_blocked, 1);
    chk(irq_valid, 0);
    @(posedge pclk);
    chk(irq_blocked, 0);
    offer(5'h02, 32'h002);
    apb(0, CTRL_OFFSET, 0);
    chk(rd, 0);
    apb(1, CTRL_OFFSET, 1);
    apb(1, CTRL_OFFSET, 2);
    chk(irq_blocked, 1);
    idle();
    wait_free();
    apb(0, CTRL_OFFSET, 0);
    chk(rd, 2);
    idle();
    lines <= 20'h1;
    offer(5'h02, BOOT + 32'h2);
    lines.self_program_ready_irq <= 1'b1;
    offer(5'h15, BOOT + 32'h28);
    apb(0, 8'h10, 0);
    chk(er, 1);
    chk(rd, 0);
    idle();
    close_out();
  end
endmodule
